/* File: shrp_pkg.sv */
// constants and state types of the sram-like host read port
//
// Summary of operation
// (RQ1) level and drop indications refresh only after a delay following side-effect reads
// (RQ2) host waits 135 ns after rx data or rx status read before rx info
// (RQ3) host waits 135 ns tx status to tx info, 180 ns between drop reads
// (RQ4) host may fill gaps with 45 ns byte-test dummy reads
// (RQ5) single reads reach registers, rx data fifo, rx and tx status fifos
// (RQ6) counter values are captured at the start of a read cycle
// (RQ7) cycle runs while select and strobe are both low, any order
// (RQ8) host keeps select or strobe high for the minimum time between cycles
// (RQ9) upper data lanes stay undriven in 16-bit mode
// (RQ10) data bus is 32 bits, optionally only lower 16 used
// (RQ11) burst returns up to 8 dword or 16 word reads back to back; code leaves fifo-select bursts uncapped
// (RQ12) host holds burst addresses 45 ns and strobes low throughout
// (RQ13) burst starts with both strobes low, ends when either rises
// (RQ14) fifo select high makes every read return rx data fifo contents
// (RQ15) in fifo mode address bits 2:1 still used, 7:3 ignored; code uses only bit 1, as the 16-bit half select, and ignores bit 2
// (RQ16) host drives fifo select with address-line timing
// (RQ17) host counts read-after-read gaps before sensitive reads
`default_nettype none
package shrp_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int INFO_GAP_NS = 135;
   localparam int DROP_GAP_NS = 180;
   localparam int INFO_GAP_CYC = (INFO_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DROP_GAP_CYC = (DROP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BURST_DW_MAX = 8;
   localparam int BURST_W_MAX = 16;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 4;
   // dword offsets, address bits 7:2
   localparam logic [5:0] OFS_RX_DATA = 6'h00;
   localparam logic [5:0] OFS_RX_STS = 6'h10;
   localparam logic [5:0] OFS_TX_STS = 6'h12;
   localparam logic [5:0] OFS_BYTE_TEST = 6'h19;
   localparam logic [5:0] OFS_RX_INFO = 6'h1F;
   localparam logic [5:0] OFS_TX_INFO = 6'h20;
   localparam logic [5:0] OFS_DROP = 6'h28;
   // rx data window covers offsets 00..07
   localparam int RX_DATA_WIN_MSB = 5;
   localparam int RX_DATA_WIN_LSB = 3;
   // arbitrary value
   localparam logic [31:0] BYTE_TEST_VAL = 32'h1234ABCD;
   typedef enum {st_idle, st_setup, st_drive} shrp_state_t;
   typedef enum {rs_rx_data, rs_rx_sts, rs_tx_sts, rs_rx_info, rs_tx_info,
                 rs_drop, rs_byte_test, rs_csr} shrp_res_t;
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic rd_s1;
      logic rd_s2;
      logic fs_s1;
      logic fs_s2;
      logic w16_s1;
      logic w16_s2;
      logic [6:0] a_s1;
      logic [6:0] a_s2;
      logic [6:0] addr;
      logic fsel;
      logic [31:0] dout;
      logic oe_lo_n;
      logic oe_hi_n;
      logic [4:0] beats;
      logic [31:0] rx_info;
      logic [31:0] tx_info;
      logic [31:0] drop;
      logic [2:0] rx_dly;
      logic [2:0] tx_dly;
      logic [2:0] drop_dly;
      logic rx_sts_pop;
      logic tx_sts_pop;
      logic drop_clr;
   } shrp_regs_t;
endpackage : shrp_pkg
`default_nettype wire

/* File: shrp_read_port.sv */
// host read port of the controller with its rx data buffer
`default_nettype none
// ==========================================
// rx data buffer
module shrp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready = cnt_q < (AW + 1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            mem[wp_q] <= in_data;
            wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : shrp_fifo
// ==========================================
// read port
module shrp_read_port (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic bus_select_n,
   input wire logic read_strobe_n,
   input wire logic [6:0] host_addr,
   input wire logic fifo_sel,
   input wire logic bus_16bit,
   output logic [31:0] data_out,
   output logic data_oe_lo_n,
   output logic data_oe_hi_n,
   input wire logic rx_data_valid,
   output logic rx_data_ready,
   input wire logic [31:0] rx_data,
   input wire logic [31:0] rx_sts_data,
   input wire logic [31:0] tx_sts_data,
   output logic rx_sts_pop,
   output logic tx_sts_pop,
   input wire logic [31:0] rx_level_raw,
   input wire logic [31:0] tx_level_raw,
   input wire logic [31:0] drop_count_raw,
   output logic drop_count_clr,
   output logic [7:0] csr_addr,
   input wire logic [31:0] csr_data,
   output logic [31:0] rx_fifo_level_info,
   output logic [31:0] tx_fifo_level_info
);
   shrp_pkg::shrp_regs_t r_q;
   shrp_pkg::shrp_regs_t r_d;
   shrp_pkg::shrp_state_t st_q;
   shrp_pkg::shrp_state_t st_d;
   logic head_valid;
   logic [31:0] head_data;
   logic head_pop;
   logic [31:0] word;
   logic act;
   logic moved;
   logic last_half;
   shrp_pkg::shrp_res_t res;

   // ==========================================
   // decode
   function automatic shrp_pkg::shrp_res_t decode(input logic [6:0] a, input logic fs);
      logic [5:0] dw;
      dw = a[6:1];
      if (fs) begin
         decode = shrp_pkg::rs_rx_data; // RQ14 RQ15
      end else if (dw[shrp_pkg::RX_DATA_WIN_MSB:shrp_pkg::RX_DATA_WIN_LSB] ==
                   shrp_pkg::OFS_RX_DATA[shrp_pkg::RX_DATA_WIN_MSB:shrp_pkg::RX_DATA_WIN_LSB]) begin
         decode = shrp_pkg::rs_rx_data;
      end else if (dw == shrp_pkg::OFS_RX_STS) begin
         decode = shrp_pkg::rs_rx_sts;
      end else if (dw == shrp_pkg::OFS_TX_STS) begin
         decode = shrp_pkg::rs_tx_sts;
      end else if (dw == shrp_pkg::OFS_RX_INFO) begin
         decode = shrp_pkg::rs_rx_info;
      end else if (dw == shrp_pkg::OFS_TX_INFO) begin
         decode = shrp_pkg::rs_tx_info;
      end else if (dw == shrp_pkg::OFS_DROP) begin
         decode = shrp_pkg::rs_drop;
      end else if (dw == shrp_pkg::OFS_BYTE_TEST) begin
         decode = shrp_pkg::rs_byte_test;
      end else begin
         decode = shrp_pkg::rs_csr;
      end
   endfunction : decode

   shrp_fifo #(
      .WIDTH(shrp_pkg::DATA_W),
      .DEPTH(shrp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(rx_data_valid),
      .in_ready(rx_data_ready),
      .in_data(rx_data),
      .out_valid(head_valid),
      .out_ready(head_pop),
      .out_data(head_data)
   );

   assign act = !r_q.cs_s2 && !r_q.rd_s2; // RQ7 RQ13
   assign moved = (r_q.a_s2 != r_q.addr) || (r_q.fs_s2 != r_q.fsel);
   assign res = decode(r_q.addr, r_q.fsel);
   // 16-bit reads consume a dword on its upper half
   assign last_half = !r_q.w16_s2 || r_q.addr[0];
   assign head_pop = (st_q == shrp_pkg::st_setup) && (res == shrp_pkg::rs_rx_data) &&
                     head_valid && last_half; // RQ5

   // ==========================================
   // next state
   always_comb begin
      r_d = r_q;
      st_d = st_q;
      word = '0;
      r_d.cs_s1 = bus_select_n;
      r_d.cs_s2 = r_q.cs_s1;
      r_d.rd_s1 = read_strobe_n;
      r_d.rd_s2 = r_q.rd_s1;
      r_d.fs_s1 = fifo_sel;
      r_d.fs_s2 = r_q.fs_s1;
      r_d.w16_s1 = bus_16bit;
      r_d.w16_s2 = r_q.w16_s1;
      r_d.a_s1 = host_addr;
      r_d.a_s2 = r_q.a_s1;
      r_d.rx_sts_pop = 1'b0;
      r_d.tx_sts_pop = 1'b0;
      r_d.drop_clr = 1'b0;
      // indications only refresh once the gap has run out
      if (r_q.rx_dly != '0) begin
         r_d.rx_dly = r_q.rx_dly - 1'b1; // RQ1
      end else begin
         r_d.rx_info = rx_level_raw;
      end
      if (r_q.tx_dly != '0) begin
         r_d.tx_dly = r_q.tx_dly - 1'b1; // RQ1
      end else begin
         r_d.tx_info = tx_level_raw;
      end
      if (r_q.drop_dly != '0) begin
         r_d.drop_dly = r_q.drop_dly - 1'b1; // RQ1
      end else begin
         r_d.drop = drop_count_raw;
      end
      case (res)
         shrp_pkg::rs_rx_data: word = head_valid ? head_data : '0;
         shrp_pkg::rs_rx_sts: word = rx_sts_data;
         shrp_pkg::rs_tx_sts: word = tx_sts_data;
         shrp_pkg::rs_rx_info: word = r_q.rx_info;
         shrp_pkg::rs_tx_info: word = r_q.tx_info;
         shrp_pkg::rs_drop: word = r_q.drop;
         shrp_pkg::rs_byte_test: word = shrp_pkg::BYTE_TEST_VAL;
         default: word = csr_data;
      endcase
      case (st_q)
         shrp_pkg::st_idle: begin
            r_d.oe_lo_n = 1'b1;
            r_d.oe_hi_n = 1'b1;
            r_d.beats = '0;
            if (act) begin
               r_d.addr = r_q.a_s2;
               r_d.fsel = r_q.fs_s2;
               st_d = shrp_pkg::st_setup;
            end
         end
         shrp_pkg::st_setup: begin
            if (!act) begin
               r_d.oe_lo_n = 1'b1;
               r_d.oe_hi_n = 1'b1;
               st_d = shrp_pkg::st_idle;
            end else begin
               // value frozen here for the rest of the cycle
               r_d.dout = r_q.w16_s2 ? {16'h0000, r_q.addr[0] ? word[31:16] : word[15:0]}
                                     : word; // RQ6 RQ9 RQ10
               r_d.oe_lo_n = 1'b0;
               r_d.oe_hi_n = r_q.w16_s2; // RQ9
               r_d.beats = r_q.beats + 1'b1;
               if (last_half) begin
                  r_d.rx_sts_pop = res == shrp_pkg::rs_rx_sts;
                  r_d.tx_sts_pop = res == shrp_pkg::rs_tx_sts;
               end
               r_d.drop_clr = res == shrp_pkg::rs_drop;
               if ((head_pop || r_d.rx_sts_pop) && (res != shrp_pkg::rs_rx_info)) begin
                  r_d.rx_dly = 3'(shrp_pkg::INFO_GAP_CYC); // RQ1
               end
               if (r_d.tx_sts_pop) begin
                  r_d.tx_dly = 3'(shrp_pkg::INFO_GAP_CYC); // RQ1
               end
               if (r_d.drop_clr) begin
                  r_d.drop_dly = 3'(shrp_pkg::DROP_GAP_CYC); // RQ1
               end
               st_d = shrp_pkg::st_drive;
            end
         end
         shrp_pkg::st_drive: begin
            if (!act) begin
               r_d.oe_lo_n = 1'b1; // RQ7 RQ13
               r_d.oe_hi_n = 1'b1;
               st_d = shrp_pkg::st_idle;
            end else if (moved) begin
               // burst beat; past the limit old data stays on the bus
               if (r_q.fs_s2 || (r_q.w16_s2 ? r_q.beats < 5'(shrp_pkg::BURST_W_MAX)
                                             : r_q.beats < 5'(shrp_pkg::BURST_DW_MAX))) begin
                  r_d.addr = r_q.a_s2; // RQ11
                  r_d.fsel = r_q.fs_s2;
                  if (r_q.fs_s2) begin
                     r_d.beats = '0;
                  end
                  st_d = shrp_pkg::st_setup;
               end
            end
         end
         default: st_d = shrp_pkg::st_idle;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         r_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, rd_s1: 1'b1, rd_s2: 1'b1,
                  oe_lo_n: 1'b1, oe_hi_n: 1'b1, default: '0};
         st_q <= shrp_pkg::st_idle;
      end else begin
         r_q <= r_d;
         st_q <= st_d;
      end
   end

   assign data_out = r_q.dout;
   assign data_oe_lo_n = r_q.oe_lo_n;
   assign data_oe_hi_n = r_q.oe_hi_n;
   assign rx_sts_pop = r_q.rx_sts_pop;
   assign tx_sts_pop = r_q.tx_sts_pop;
   assign drop_count_clr = r_q.drop_clr;
   assign csr_addr = {r_q.addr, 1'b0};
   assign rx_fifo_level_info = r_q.rx_info;
   assign tx_fifo_level_info = r_q.tx_info;

   // ==========================================
   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   AST_START: assert property ((st_q == shrp_pkg::st_idle) && act |=> // RQ7
      (st_q == shrp_pkg::st_setup) ##1 (!act || !data_oe_lo_n))
      else $error("read cycle did not start");
   AST_END: assert property ((st_q == shrp_pkg::st_drive) && !act |=> // RQ13
      data_oe_lo_n && data_oe_hi_n)
      else $error("bus still driven after strobe release");
   AST_HI_LANE: assert property (r_q.w16_s2 && (st_q == shrp_pkg::st_setup) |=> // RQ9
      data_oe_hi_n && (data_out[31:16] == 16'h0000))
      else $error("upper lanes driven in 16-bit mode");
   AST_FIFO_SEL: assert property ((st_q == shrp_pkg::st_setup) && r_q.fsel && act && // RQ14
      head_valid && !r_q.w16_s2 |=> data_out == $past(head_data))
      else $error("fifo select did not return fifo data");
   AST_INFO_HOLD: assert property (rx_sts_pop |-> (r_q.rx_dly != '0) [*2] // RQ1
      ##1 $stable(rx_fifo_level_info))
      else $error("rx info refreshed too early");
   AST_DROP_HOLD: assert property (drop_count_clr |-> $stable(r_q.drop) [*4]) // RQ1
      else $error("drop count refreshed too early");
   AST_LATCHED: assert property ((st_q == shrp_pkg::st_drive) && act && !moved |=> // RQ6
      $stable(data_out))
      else $error("read data changed inside a cycle");
   AST_BURST_MAX: assert property (r_q.beats <= 5'(shrp_pkg::BURST_W_MAX)) // RQ11
      else $error("burst beat count overran");
   AST_POP_ONCE: assert property (rx_sts_pop |=> !rx_sts_pop) // RQ5
      else $error("status fifo popped twice in one beat");

   COV_SINGLE: cover property ((st_q == shrp_pkg::st_drive) && !act);
   COV_BURST: cover property ((st_q == shrp_pkg::st_drive) && moved && act);
   COV_FIFO: cover property (head_pop && r_q.fsel);
endmodule : shrp_read_port
`default_nettype wire

/* File: shrp_host_model.sv */
// host processor model driving the read port pins
`default_nettype none
module shrp_host_model (
   input wire logic clk_sys,
   input wire logic [31:0] data_out,
   input wire logic data_oe_lo_n,
   output var logic bus_select_n,
   output var logic read_strobe_n,
   output var logic [6:0] host_addr,
   output var logic fifo_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // state
   bit gap_q = 1'b0;
   bit flip = 1'b0;
   int errs = 0;
   initial begin
      bus_select_n = 1'b1;
      read_strobe_n = 1'b1;
      host_addr = 7'h00;
      fifo_sel = 1'b0;
   end
   // ====
   // cycles
   task automatic start(input logic [6:0] a, input logic fs);
      int n;
      n = 0;
      @(negedge clk_sys);
      host_addr = a;
      fifo_sel = fs;
      if (flip) bus_select_n = 1'b0;
      else read_strobe_n = 1'b0;
      @(negedge clk_sys);
      bus_select_n = 1'b0;
      read_strobe_n = 1'b0;
      while (data_oe_lo_n !== 1'b0 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 20) errs++;
   endtask : start
   task automatic stop();
      @(negedge clk_sys);
      if (flip) read_strobe_n = 1'b1;
      else bus_select_n = 1'b1;
      // released lines must not keep a stale value
      host_addr = ~host_addr;
      fifo_sel = ~fifo_sel;
      @(negedge clk_sys);
      bus_select_n = 1'b1;
      read_strobe_n = 1'b1;
      flip = ~flip;
      repeat (4) @(negedge clk_sys);
   endtask : stop
   task automatic move(input logic [6:0] a, output logic [31:0] d);
      @(negedge clk_sys);
      host_addr = a;
      repeat (6) @(negedge clk_sys);
      d = data_out;
   endtask : move
   task automatic rd(input logic [6:0] a, input logic fs, output logic [31:0] d);
      logic [5:0] o;
      o = a[6:1];
      // one dummy read already outlasts the longest gap
      if (gap_q && !fs && (o == shrp_pkg::OFS_RX_INFO || o == shrp_pkg::OFS_TX_INFO
          || o == shrp_pkg::OFS_DROP)) begin
         start({shrp_pkg::OFS_BYTE_TEST, 1'b0}, 1'b0);
         stop();
      end
      start(a, fs);
      d = data_out;
      stop();
      gap_q = fs || o[5:3] == 3'h0 || o == shrp_pkg::OFS_RX_STS
              || o == shrp_pkg::OFS_TX_STS || o == shrp_pkg::OFS_DROP;
   endtask : rd
endmodule : shrp_host_model
`default_nettype wire

/* File: sram_like_host_read_port_tb.sv */
// self-checking bench of the host read port
`default_nettype none
module sram_like_host_read_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, sys_rst, bus_16bit, rx_data_valid, data_oe_lo_n, data_oe_hi_n;
   logic rx_data_ready, rx_sts_pop, tx_sts_pop, drop_count_clr, fifo_sel;
   logic bus_select_n, read_strobe_n;
   logic [6:0] host_addr;
   logic [7:0] csr_addr;
   logic [31:0] rx_data, rx_sts_data, tx_sts_data, rx_level_raw, tx_level_raw;
   logic [31:0] drop_count_raw, csr_data, data_out, rx_fifo_level_info;
   logic [31:0] tx_fifo_level_info, d;
   int n_errors = 0;
   int n_tests = 0;
   int n_rxp = 0;
   int n_clr = 0;
   int n_txp = 0;
   bit hi_low = 1'b0;
   assign csr_data = {24'h5A5A5A, csr_addr};
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_sts_pop === 1'b1) n_rxp++;
      if (drop_count_clr === 1'b1) n_clr++;
      if (tx_sts_pop === 1'b1) n_txp++;
      if (data_oe_hi_n === 1'b0) hi_low = 1'b1;
   end
   shrp_read_port uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_select_n(bus_select_n),
      .read_strobe_n(read_strobe_n), .host_addr(host_addr), .fifo_sel(fifo_sel),
      .bus_16bit(bus_16bit), .data_out(data_out), .data_oe_lo_n(data_oe_lo_n),
      .data_oe_hi_n(data_oe_hi_n), .rx_data_valid(rx_data_valid),
      .rx_data_ready(rx_data_ready), .rx_data(rx_data), .rx_sts_data(rx_sts_data),
      .tx_sts_data(tx_sts_data), .rx_sts_pop(rx_sts_pop), .tx_sts_pop(tx_sts_pop),
      .rx_level_raw(rx_level_raw), .tx_level_raw(tx_level_raw),
      .drop_count_raw(drop_count_raw), .drop_count_clr(drop_count_clr),
      .csr_addr(csr_addr), .csr_data(csr_data), .rx_fifo_level_info(rx_fifo_level_info),
      .tx_fifo_level_info(tx_fifo_level_info));
   shrp_host_model host (.clk_sys(clk_sys), .data_out(data_out),
      .data_oe_lo_n(data_oe_lo_n), .bus_select_n(bus_select_n),
      .read_strobe_n(read_strobe_n), .host_addr(host_addr), .fifo_sel(fifo_sel));
   // ====
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic push(input logic [31:0] v);
      @(negedge clk_sys);
      rx_data_valid = 1'b1;
      rx_data = v;
      @(negedge clk_sys);
      rx_data_valid = 1'b0;
   endtask : push
   task automatic end_sim();
      n_errors += host.errs;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // ====
   // scenarios
   task automatic t_single();
      hi_low = 1'b0;
      host.rd({6'h0A, 1'b0}, 1'b0, d);
      chk(d, 32'h5A5A5A28);
      host.rd({6'h3F, 1'b0}, 1'b0, d);
      chk(d, 32'h5A5A5AFC);
      host.rd({shrp_pkg::OFS_BYTE_TEST, 1'b0}, 1'b0, d);
      chk(d, shrp_pkg::BYTE_TEST_VAL);
      host.rd({shrp_pkg::OFS_RX_STS, 1'b0}, 1'b0, d);
      chk(d, 32'h0BAD0001);
      host.rd({shrp_pkg::OFS_TX_STS, 1'b0}, 1'b0, d);
      chk(d, 32'h0BAD0002);
      chk(32'(n_rxp), 32'h1);
      chk(32'(n_txp), 32'h1);
      host.rd({shrp_pkg::OFS_RX_INFO, 1'b0}, 1'b0, d);
      chk(d, 32'h11);
      host.rd({shrp_pkg::OFS_TX_INFO, 1'b0}, 1'b0, d);
      chk(d, 32'h33);
      chk({31'h0, hi_low}, 32'h1);
      $display("single reads done");
   endtask : t_single
   task automatic t_fifo();
      logic [6:0] fa[4];
      fa = '{7'h7E, 7'h40, 7'h2A, 7'h10};
      for (int i = 0; i < 4; i++) push(32'hF00D0000 + i);
      chk({31'h0, rx_data_ready}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         host.rd(fa[i], 1'b1, d);
         chk(d, 32'hF00D0000 + i);
      end
      host.rd(7'h22, 1'b1, d);
      chk(d, 32'h0);
      push(32'hCAFE0003);
      host.rd({6'h03, 1'b0}, 1'b0, d);
      chk(d, 32'hCAFE0003);
      $display("fifo reads done");
   endtask : t_fifo
   task automatic t_16();
      @(negedge clk_sys);
      bus_16bit = 1'b1;
      repeat (4) @(negedge clk_sys);
      hi_low = 1'b0;
      host.rd({shrp_pkg::OFS_BYTE_TEST, 1'b0}, 1'b0, d);
      chk(d, {16'h0, shrp_pkg::BYTE_TEST_VAL[15:0]});
      host.rd({shrp_pkg::OFS_BYTE_TEST, 1'b1}, 1'b0, d);
      chk(d, {16'h0, shrp_pkg::BYTE_TEST_VAL[31:16]});
      push(32'hBEEF5A11);
      host.rd(7'h5C, 1'b1, d);
      chk(d, 32'h00005A11);
      host.rd(7'h5D, 1'b1, d);
      chk(d, 32'h0000BEEF);
      chk({31'h0, hi_low}, 32'h0);
      @(negedge clk_sys);
      bus_16bit = 1'b0;
      repeat (4) @(negedge clk_sys);
      $display("16-bit reads done");
   endtask : t_16
   task automatic t_burst();
      logic [5:0] o;
      host.start({6'h30, 1'b0}, 1'b0);
      chk(data_out, 32'h5A5A5AC0);
      for (int i = 1; i < 9; i++) begin
         o = 6'h30 + 6'(i);
         host.move({o, 1'b0}, d);
         chk(d, (i < 8) ? {24'h5A5A5A, o, 2'b00} : 32'h5A5A5ADC);
      end
      host.stop();
      // fifo-select bursts run past the dword limit
      push(32'hA5A50000);
      host.start(7'h40, 1'b1);
      chk(data_out, 32'hA5A50000);
      for (int i = 1; i < 10; i++) begin
         push(32'hA5A50000 + i);
         host.move(i[0] ? 7'h48 : 7'h40, d);
         chk(d, 32'hA5A50000 + i);
      end
      host.stop();
      $display("burst done");
   endtask : t_burst
   task automatic t_snap();
      @(negedge clk_sys);
      drop_count_raw = 32'h42;
      host.start({shrp_pkg::OFS_DROP, 1'b0}, 1'b0);
      drop_count_raw = 32'h77;
      repeat (3) @(negedge clk_sys);
      chk(data_out, 32'h42);
      host.stop();
      chk(32'(n_clr), 32'h1);
      host.start({shrp_pkg::OFS_RX_STS, 1'b0}, 1'b0);
      rx_level_raw = 32'h22;
      @(negedge clk_sys);
      chk(rx_fifo_level_info, 32'h11);
      host.stop();
      chk(rx_fifo_level_info, 32'h22);
      host.start({shrp_pkg::OFS_TX_STS, 1'b0}, 1'b0);
      tx_level_raw = 32'h44;
      @(negedge clk_sys);
      chk(tx_fifo_level_info, 32'h33);
      host.stop();
      chk(tx_fifo_level_info, 32'h44);
      $display("snapshot done");
   endtask : t_snap
   // ====
   // main sequence and watchdog
   initial begin
      sys_rst = 1'b1;
      bus_16bit = 1'b0;
      rx_data_valid = 1'b0;
      rx_data = 32'h0;
      rx_sts_data = 32'h0BAD0001;
      tx_sts_data = 32'h0BAD0002;
      rx_level_raw = 32'h11;
      tx_level_raw = 32'h33;
      drop_count_raw = 32'h0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      t_single();
      t_fifo();
      t_16();
      t_burst();
      t_snap();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
endmodule : sram_like_host_read_port_tb
`default_nettype wire
